/* fmc_pkg.sv */
// constants and types for the flash mode, power-down and crc command block
package fmc_pkg;
  // command and sequence codes
  localparam logic [7:0] OP_ENTER_4B = 8'hb7;
  localparam logic [7:0] OP_EXIT_4B = 8'he9;
  localparam logic [7:0] OP_PD_ENTER = 8'hb9;
  localparam logic [7:0] OP_PD_RELEASE = 8'hab;
  localparam logic [7:0] OP_QUAD_ENTER = 8'h35;
  localparam logic [7:0] OP_QUAD_EXIT = 8'hf5;
  localparam logic [7:0] OP_ACTIVATE = 8'h9b;
  localparam logic [7:0] OP_CRC_SUB = 8'h27;
  localparam logic [7:0] OPT_WHOLE = 8'hff;
  localparam logic [7:0] OPT_RANGE = 8'hfe;
  localparam logic [7:0] OP_READ_BUF = 8'h96;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_CLR_FLAG = 8'h50;
  // sequence lengths in bytes, opcode included
  localparam logic [4:0] WHOLE_SEQ_BYTES = 5'h0b;
  localparam logic [4:0] RANGE_SEQ_BYTES = 5'h13;
  localparam logic [4:0] FIRST_ARG_BYTE = 5'h03;
  localparam logic [3:0] CRC_BYTES = 4'h8;
  // crc-64 generator, x^64 implicit
  localparam logic [63:0] CRC_POLY = 64'h42f0e1eba9ea3693;
  // timing: least times, rounded up to whole 10 ns cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_DP_NS = 3000;
  localparam int T_RDP_NS = 30000;
  localparam int T_RST_NS = 30000;
  localparam int DP_CYC = (T_DP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RDP_CYC = (T_RDP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYC = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W = 16;
  // register map (byte addresses)
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_BUF_LO = 12'h004;
  localparam logic [11:0] REG_BUF_HI = 12'h008;
  localparam int FAIL_BIT = 4;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // status word, four_byte is bit 0 and crc_fail is bit 4
  typedef struct packed {
    logic pending;
    logic wpl;
    logic crc_fail;
    logic crc_busy;
    logic power_down;
    logic quad;
    logic four_byte;
  } fmc_status_s;
  typedef enum logic [3:0] {
    FS_CMD = 4'b0001, FS_ARGS = 4'b0010, FS_READ = 4'b0100, FS_SINK = 4'b1000
  } fmc_frame_e;
  typedef enum logic [3:0] {
    PS_ACTIVE = 4'b0001, PS_ENTERING = 4'b0010, PS_DOWN = 4'b0100,
    PS_LEAVING = 4'b1000
  } fmc_power_e;
  typedef enum logic [4:0] {
    ES_IDLE = 5'b00001, ES_FETCH = 5'b00010, ES_LOAD = 5'b00100,
    ES_SHIFT = 5'b01000, ES_DONE = 5'b10000
  } fmc_engine_e;
endpackage

/* fmc_cmd.sv */
// flash command interpreter: address mode, power-down, quad mode and crc-64
//
// Summary of operation
// - enter code selects four-byte addressing at once, exit code restores three
// - power-down entry takes effect only after the entry delay past select high
// - power-down entry is refused while a write operation or crc runs
// - while powered down no flags are set and write latch is kept
// - powered down, only release, reset-enable, reset and hardware reset act
// - release is void when any clock follows its eight command bits
// - after release, standby comes only after the exit delay
// - hardware or software reset also leaves power-down after recovery time
// - quad entry and exit codes switch protocol right after the command
// - crc uses 64-bit generator 42f0e1eba9ea3693 with implicit top term
// - data fed least significant bit first from an all-zero start
// - result is compared with expected value, mismatch sets flag bit 4
// - readback buffer takes the crc only on a mismatch
// - readback command outputs buffer least significant byte first
// - buffer cleared to zero when every crc operation starts
// - buffer cleared at power-up and on hardware or software reset
// - readback starts at first byte and gives zero bytes past the end
// - crc starts only when select rises right after the last byte
// - range option adds four-byte start and stop addresses, lsb first
`timescale 1ns/1ps
`default_nettype none
module fmc_cmd
  import fmc_pkg::*;
#(
  parameter int ADDR_W = 25,
  parameter int ARRAY_BYTES = 33554432
) (
  input wire logic clk, // 100 MHz system clock
  input wire logic sys_rst, // asynchronous reset, power-up
  input wire logic link_sel_n, // select pin, active low
  input wire logic link_sck, // serial clock pin
  input wire logic [3:0] serial_io_lines_in, // data pins, input side
  output logic [3:0] serial_io_lines_out, // data pins, driven value
  output logic [3:0] serial_io_lines_oe_n, // low while driving
  input wire logic hw_rst_n, // hardware reset pin, active low
  input wire logic write_busy, // array write in progress
  output logic mem_rd_en, // array read strobe
  output logic [ADDR_W-1:0] mem_rd_addr, // array byte address
  input wire logic [7:0] mem_rd_data, // array data, one cycle later
  output fmc_status_s status, // mode and status bits
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr // apb error, unmapped address
);
  ////////////////////////////////////////////////////////////////////////////
  fmc_frame_e frame;
  fmc_power_e pwr, pwr_d;
  fmc_engine_e eng;
  logic sel_s1, sel_s2, sel_d, sck_s1, sck_s2, sck_d, hw_s1, hw_s2, hw_d;
  logic [3:0] io_s1, io_s2;
  logic sck_rise, sck_fall, sel_rise, sel_fall, hw_fall;
  logic [7:0] sh, opcode, opt, new_byte, rd_sh;
  logic [2:0] bit_cnt, rd_cnt;
  logic [4:0] byte_cnt, arg_idx;
  logic [127:0] args;
  logic sub_ok, byte_done, exact, cmd_done, single_op, seq_ok, pd_now;
  logic rst_armed, soft_rst, eng_start, four_byte, quad, wpl, crc_fail;
  logic [DLY_W-1:0] dly, lv_need, ph_cyc;
  logic [ADDR_W-1:0] addr, stop;
  logic [63:0] crc, exp_crc, rbuf;
  logic [7:0] dbyte;
  logic [2:0] nbit;
  logic [3:0] rd_idx;
  logic drive, fail_set, fail_clr, apb_wr;
  logic [31:0] rd_mux;

  // byte of the readback buffer, zero past its last location
  function automatic logic [7:0] buf_byte(input logic [63:0] b,
                                          input logic [3:0] idx);
    buf_byte = (idx < CRC_BYTES) ? b[{idx[2:0], 3'b000} +: 8] : 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the link clock is only sampled, never used as a clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_d <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_d <= 1'b0;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
      hw_s1 <= 1'b1;
      hw_s2 <= 1'b1;
      hw_d <= 1'b1;
    end else begin
      sel_s1 <= link_sel_n;
      sel_s2 <= sel_s1;
      sel_d <= sel_s2;
      sck_s1 <= link_sck;
      sck_s2 <= sck_s1;
      sck_d <= sck_s2;
      io_s1 <= serial_io_lines_in;
      io_s2 <= io_s1;
      hw_s1 <= hw_rst_n;
      hw_s2 <= hw_s1;
      hw_d <= hw_s2;
    end
  end

  // edges, seen on the second stage only
  assign sck_rise = sck_s2 & ~sck_d & ~sel_s2;
  assign sck_fall = ~sck_s2 & sck_d & ~sel_s2;
  assign sel_rise = sel_s2 & ~sel_d;
  assign sel_fall = ~sel_s2 & sel_d;
  assign hw_fall = ~hw_s2 & hw_d;

  ////////////////////////////////////////////////////////////////////////////
  // serial byte assembly, four bits a clock in quad protocol
  assign new_byte = quad ? {sh[3:0], io_s2} : {sh[6:0], io_s2[0]};
  assign byte_done = quad ? bit_cnt[2] : (bit_cnt == 3'h7);
  assign exact = (bit_cnt == 3'h0);
  assign cmd_done = sck_rise & byte_done & (frame == FS_CMD);
  assign single_op = sel_rise & exact & (byte_cnt == 5'h01);
  assign pd_now = (pwr == PS_DOWN) | (pwr == PS_LEAVING);
  assign arg_idx = byte_cnt - FIRST_ARG_BYTE;
  // extra bits after the last byte leave exact low, or whole extra bytes change byte_cnt, and void the frame
  assign seq_ok = (frame == FS_ARGS) & exact & sub_ok &
    (((opt == OPT_WHOLE) & (byte_cnt == WHOLE_SEQ_BYTES)) |
     ((opt == OPT_RANGE) & (byte_cnt == RANGE_SEQ_BYTES)));

  // frame decoder: opcode, sub-command, option and argument bytes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame <= FS_CMD;
      sh <= 8'h00;
      bit_cnt <= 3'h0;
      byte_cnt <= 5'h00;
      opcode <= 8'h00;
      opt <= 8'h00;
      sub_ok <= 1'b0;
      args <= '0;
    end else if (sel_fall) begin
      frame <= FS_CMD;
      bit_cnt <= 3'h0;
      byte_cnt <= 5'h00;
      sub_ok <= 1'b0;
    end else if (sck_rise) begin
      sh <= new_byte;
      bit_cnt <= bit_cnt + (quad ? 3'h4 : 3'h1);
      if (byte_done) begin
        if (byte_cnt != 5'h1f) begin
          byte_cnt <= byte_cnt + 5'h01;
        end
        case (frame)
          FS_CMD: begin
            opcode <= new_byte;
            if (pd_now) begin
              frame <= FS_SINK;
            end else if (new_byte == OP_ACTIVATE) begin
              frame <= FS_ARGS;
            end else if (new_byte == OP_READ_BUF) begin
              frame <= FS_READ;
            end else begin
              frame <= FS_SINK;
            end
          end
          FS_ARGS: begin
            if (byte_cnt == 5'h01) begin
              sub_ok <= (new_byte == OP_CRC_SUB);
            end else if (byte_cnt == 5'h02) begin
              opt <= new_byte;
            end else if (byte_cnt < RANGE_SEQ_BYTES) begin
              args[{arg_idx[3:0], 3'b000} +: 8] <= new_byte;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset-enable must be the frame just before reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_armed <= 1'b0;
    end else if (sel_rise && byte_cnt != 5'h00) begin
      rst_armed <= single_op & (opcode == OP_RST_EN);
    end
  end
  assign soft_rst = (single_op & (opcode == OP_RST) & rst_armed) | hw_fall;

  // power state; counters load target-1 so the state lasts the full count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr <= PS_ACTIVE; // power loss ends in standby at power-up
      dly <= '0;
      lv_need <= '0;
    end else if (soft_rst) begin
      if (pd_now) begin
        pwr <= PS_LEAVING;
        dly <= DLY_W'(RST_CYC - 1);
        lv_need <= DLY_W'(RST_CYC);
      end else begin
        pwr <= PS_ACTIVE;
      end
    end else begin
      case (pwr)
        PS_ACTIVE: begin
          // a write or crc in flight is left alone
          if (single_op && opcode == OP_PD_ENTER &&
              !write_busy && eng == ES_IDLE) begin
            pwr <= PS_ENTERING;
            dly <= DLY_W'(DP_CYC - 1);
          end
        end
        PS_ENTERING: begin
          if (dly == '0) begin
            pwr <= PS_DOWN;
          end else begin
            dly <= dly - 1'b1;
          end
        end
        PS_DOWN: begin
          if (single_op && opcode == OP_PD_RELEASE) begin
            pwr <= PS_LEAVING;
            dly <= DLY_W'(RDP_CYC - 1);
            lv_need <= DLY_W'(RDP_CYC);
          end
        end
        PS_LEAVING: begin
          if (dly == '0) begin
            pwr <= PS_ACTIVE;
          end else begin
            dly <= dly - 1'b1;
          end
        end
        default: pwr <= PS_ACTIVE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode latches change on the last command bit, not at select high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      four_byte <= 1'b0;
      quad <= 1'b0;
      wpl <= 1'b0;
    end else if (soft_rst) begin
      four_byte <= 1'b0;
      quad <= 1'b0;
      wpl <= 1'b0;
    end else if (cmd_done && !pd_now) begin
      case (new_byte)
        OP_ENTER_4B: four_byte <= 1'b1;
        OP_EXIT_4B: four_byte <= 1'b0;
        OP_QUAD_ENTER: quad <= 1'b1;
        OP_QUAD_EXIT: quad <= 1'b0;
        OP_WR_EN: wpl <= 1'b1;
        OP_WR_DIS: wpl <= 1'b0;
        default: begin
        end
      endcase
    end
  end

  // failure flag; a mismatch in the clearing cycle still sets it
  assign fail_set = (eng == ES_DONE) & (crc != exp_crc);
  assign fail_clr = soft_rst | (apb_wr & paddr == REG_STATUS &
    pwdata[FAIL_BIT]) | (cmd_done & !pd_now & new_byte == OP_CLR_FLAG);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc_fail <= 1'b0;
    end else begin
      crc_fail <= fail_set | (crc_fail & ~fail_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crc engine: one array byte fetched, then eight shift cycles
  assign eng_start = sel_rise & seq_ok & (eng == ES_IDLE);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      eng <= ES_IDLE;
      addr <= '0;
      stop <= '0;
      crc <= 64'h0;
      exp_crc <= 64'h0;
      rbuf <= 64'h0;
      dbyte <= 8'h00;
      nbit <= 3'h0;
    end else if (soft_rst) begin
      eng <= ES_IDLE;
      rbuf <= 64'h0;
    end else begin
      case (eng)
        ES_IDLE: begin
          if (eng_start) begin
            eng <= ES_FETCH;
            crc <= 64'h0;
            rbuf <= 64'h0;
            exp_crc <= args[63:0];
            if (opt == OPT_RANGE) begin
              addr <= args[64 +: ADDR_W];
              stop <= args[96 +: ADDR_W];
            end else begin
              addr <= '0;
              stop <= ADDR_W'(ARRAY_BYTES - 1);
            end
          end
        end
        ES_FETCH: eng <= ES_LOAD;
        ES_LOAD: begin
          dbyte <= mem_rd_data;
          nbit <= 3'h0;
          eng <= ES_SHIFT;
        end
        ES_SHIFT: begin
          // lsb of the byte goes in first, msb of the register falls out
          crc <= {crc[62:0], 1'b0} ^
            ((crc[63] ^ dbyte[0]) ? CRC_POLY : 64'h0);
          dbyte <= {1'b0, dbyte[7:1]};
          nbit <= nbit + 3'h1;
          if (nbit == 3'h7) begin
            // a start above the stop address checks one byte only
            if (addr >= stop) begin
              eng <= ES_DONE;
            end else begin
              addr <= addr + 1'b1;
              eng <= ES_FETCH;
            end
          end
        end
        ES_DONE: begin
          if (crc != exp_crc) begin
            rbuf <= crc;
          end
          eng <= ES_IDLE;
        end
        default: eng <= ES_IDLE;
      endcase
    end
  end
  assign mem_rd_en = (eng == ES_FETCH);
  assign mem_rd_addr = addr;

  ////////////////////////////////////////////////////////////////////////////
  // readback output, shifted on falling link clock edges, byte msb first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_sh <= 8'h00;
      rd_idx <= 4'h0;
      rd_cnt <= 3'h0;
      drive <= 1'b0;
      serial_io_lines_out <= 4'h0;
    end else if (sel_s2) begin
      drive <= 1'b0;
    end else if (cmd_done && !pd_now && new_byte == OP_READ_BUF) begin
      rd_sh <= buf_byte(rbuf, 4'h0);
      rd_idx <= 4'h1;
      rd_cnt <= 3'h0;
    end else if (sck_fall && frame == FS_READ) begin
      drive <= 1'b1;
      serial_io_lines_out <= quad ? rd_sh[7:4] : {2'b00, rd_sh[7], 1'b0};
      if (quad ? (rd_cnt == 3'h1) : (rd_cnt == 3'h7)) begin
        rd_sh <= buf_byte(rbuf, rd_idx);
        rd_cnt <= 3'h0;
        if (rd_idx != CRC_BYTES) begin
          rd_idx <= rd_idx + 4'h1;
        end
      end else begin
        rd_sh <= quad ? {rd_sh[3:0], 4'h0} : {rd_sh[6:0], 1'b0};
        rd_cnt <= rd_cnt + 3'h1;
      end
    end
  end
  // single protocol drives only line 1
  assign serial_io_lines_oe_n = !drive ? 4'hf : (quad ? 4'h0 : 4'hd);

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, read data captured in the setup cycle
  assign status = '{pending: (pwr == PS_ENTERING) | (pwr == PS_LEAVING),
                    wpl: wpl, crc_fail: crc_fail, crc_busy: eng != ES_IDLE,
                    power_down: pwr == PS_DOWN, quad: quad,
                    four_byte: four_byte};
  assign pready = 1'b1;
  assign apb_wr = psel & penable & pwrite;
  always_comb begin
    case (paddr)
      REG_STATUS: rd_mux = {25'h0, status};
      REG_BUF_LO: rd_mux = rbuf[31:0];
      REG_BUF_HI: rd_mux = rbuf[63:32];
      default: rd_mux = RESET_WORD;
    endcase
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= RESET_WORD;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? RESET_WORD : rd_mux;
      pslverr <= (paddr != REG_STATUS) && (paddr != REG_BUF_LO) &&
        (paddr != REG_BUF_HI);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper: cycles spent in the current power state, saturating
  // pwr_d is a plain register so the count needs no sampled-value call
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_d <= PS_ACTIVE;
      ph_cyc <= '0;
    end else begin
      pwr_d <= pwr;
      if (pwr != pwr_d) begin
        ph_cyc <= DLY_W'(1);
      end else if (ph_cyc != '1) begin
        ph_cyc <= ph_cyc + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_four_byte_enter: assert property (cmd_done && !pd_now &&
    new_byte == OP_ENTER_4B |=> four_byte && status.four_byte)
    else $error("four-byte mode not entered after enter code");
  a_pd_entry_delay: assert property ($past(pwr) == PS_ENTERING &&
    pwr == PS_DOWN |-> ph_cyc == DLY_W'(DP_CYC))
    else $error("power-down reached before entry delay");
  a_pd_busy_reject: assert property (single_op && !soft_rst &&
    opcode == OP_PD_ENTER && pwr == PS_ACTIVE && write_busy
    |=> pwr == PS_ACTIVE [*2])
    else $error("power-down entered during write");
  a_pd_flags_held: assert property (pwr == PS_DOWN && !soft_rst
    |=> $stable(wpl) && !$rose(crc_fail))
    else $error("flag or write latch changed in power-down");
  a_pd_cmd_ignored: assert property (pwr == PS_DOWN && cmd_done &&
    !soft_rst |=> $stable(four_byte) && $stable(quad) && frame == FS_SINK)
    else $error("command acted in power-down");
  a_release_voided: assert property (sel_rise && opcode == OP_PD_RELEASE
    && !exact && pwr == PS_DOWN && !soft_rst |=> pwr == PS_DOWN)
    else $error("release acted with extra clocks");
  a_release_delay: assert property ($past(pwr) == PS_LEAVING &&
    pwr == PS_ACTIVE && !$past(soft_rst) |-> ph_cyc == lv_need)
    else $error("standby reached before exit delay");
  a_quad_switch: assert property (cmd_done && !pd_now &&
    new_byte == OP_QUAD_ENTER |=> quad ##1 quad)
    else $error("quad protocol not entered");
  a_crc_start_clear: assert property (eng_start && !soft_rst
    |=> rbuf == 64'h0 && eng == ES_FETCH)
    else $error("buffer not cleared at crc start");
  a_crc_fail_store: assert property (eng == ES_DONE && !soft_rst &&
    crc != exp_crc |=> crc_fail && rbuf == $past(crc))
    else $error("crc mismatch not reported");
  a_crc_pass_keep: assert property (eng == ES_DONE && !soft_rst &&
    crc == exp_crc |=> rbuf == 64'h0)
    else $error("buffer written on crc pass");
endmodule // fmc_cmd
`default_nettype wire

/* fmc_host.sv */
// host serial controller model: select, link clock and data lines
`timescale 1ns/1ps
`default_nettype none
module fmc_host (
  output logic sel_n, // select, active low
  output logic sck, // link clock, still low between frames
  output logic [3:0] dq, // lines driven toward the device
  input wire logic [3:0] dq_dev // resolved line level
);
  logic [7:0] rd_q[$];
  // idle: deselected, clock low
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    dq = 4'h5;
  end
  // one 80 ns link clock, data set up while the clock is low
  task automatic put(input logic [3:0] v);
    dq = v;
    #40 sck = 1'b1;
    #40 sck = 1'b0;
  endtask
  // bytes msb first, then extra clocks, then reads, four lines a clock when qd is set
  task automatic frame(input logic [7:0] b[$], input int extra,
                       input bit qd, input int nrd);
    logic [7:0] r;
    #3; // keep pin changes off the system clock edge
    sel_n = 1'b0;
    rd_q.delete();
    #40;
    foreach (b[i]) for (int k = 0; k < 8; k += qd ? 4 : 1)
      put(qd ? b[i][7-k -: 4] : {3'h0, b[i][7-k]});
    repeat (extra) put(~dq);
    repeat (nrd) begin
      for (int k = 0; k < 8; k += qd ? 4 : 1) begin
        #40 sck = 1'b1;
        r = qd ? {r[3:0], dq_dev} : {r[6:0], dq_dev[1]};
        #40 sck = 1'b0;
      end
      rd_q.push_back(r);
    end
    // select rises right after the last bit and stays high well past 8 clk
    #40 sel_n = 1'b1;
    dq = ~dq;
    #200;
  endtask
endmodule // fmc_host
`default_nettype wire

/* flash_mode_power_crc_commands_test.sv */
// self-checking bench: apb reads, host frames, crc worked out here
`timescale 1ns/1ps
`default_nettype none
module flash_mode_power_crc_commands_test;
  import fmc_pkg::*;
  logic clk, sys_rst, hw_rst_n, write_busy, psel, penable, pwrite, pready;
  logic pslverr, sel_n, sck, mem_rd_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] hdq, dout, oe_n, mem_rd_addr;
  logic [7:0] mem_rd_data;
  logic [63:0] crc;
  fmc_status_s status;
  int err_total = 0, samples_checked = 0, cyc = 0;
  // device wins a line wherever its enable is low
  wire logic [3:0] dq = (dout & ~oe_n) | (hdq & oe_n);
  fmc_host h (.sel_n(sel_n), .sck(sck), .dq(hdq), .dq_dev(dq));
  fmc_cmd #(.ADDR_W(4), .ARRAY_BYTES(16)) DUT (.clk(clk), .sys_rst(sys_rst),
    .link_sel_n(sel_n), .link_sck(sck), .serial_io_lines_in(dq),
    .serial_io_lines_out(dout), .serial_io_lines_oe_n(oe_n),
    .hw_rst_n(hw_rst_n), .write_busy(write_busy), .mem_rd_en(mem_rd_en),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .status(status),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  always #5 clk = ~clk;
  // array model: byte at a is {a, ~a}, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (mem_rd_en) begin
      mem_rd_data <= {mem_rd_addr, ~mem_rd_addr};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] crc_of(input int lo, input int hi);
    logic [63:0] c = 64'h0;
    logic [7:0] b;
    for (int a = lo; a <= hi; a++) begin
      b = {a[3:0], ~a[3:0]};
      for (int k = 0; k < 8; k++)
        c = {c[62:0], 1'b0} ^ ((c[63] ^ b[k]) ? CRC_POLY : 64'h0);
    end
    return c;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  // apb: setup, access until pready, release, one idle edge
  task automatic apb(input logic w, input logic [11:0] a);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'h10;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bufchk(input logic [63:0] e);
    apb(1'b0, REG_BUF_LO);
    chk(rd, e[31:0]);
    chk(pslverr, 1'b0);
    apb(1'b0, REG_BUF_HI);
    chk(rd, e[63:32]);
  endtask
  task automatic send(input logic [7:0] b[$], input int extra, input int n);
    h.frame(b, extra, status.quad, n);
    repeat (6) @(posedge clk);
  endtask
  // crc sequence; cut drops trailing bytes to make it short
  task automatic crc_run(input logic [7:0] opt, input logic [63:0] e,
                         input int lo, input int hi, input int cut);
    logic [7:0] q[$];
    q = {OP_ACTIVATE, OP_CRC_SUB, opt};
    for (int i = 0; i < 8; i++) q.push_back(e[8*i +: 8]);
    if (opt == OPT_RANGE) for (int i = 0; i < 8; i++)
      q.push_back(i == 0 ? 8'(lo) : i == 4 ? 8'(hi) : 8'h0);
    repeat (cut) void'(q.pop_back());
    send(q, 0, 0);
    for (int i = 0; i < 400 && status.crc_busy !== 1'b0; i++) @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    {clk, sys_rst, hw_rst_n, write_busy, psel, penable, pwrite} = 7'h30;
    {paddr, pwdata} = '0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    bufchk(64'h0);
    apb(1'b0, 12'h00c);
    chk(pslverr, 1'b1);
    chk(rd, 32'h0);
    send('{OP_ENTER_4B}, 0, 0);
    chk(status.four_byte, 1'b1);
    send('{OP_EXIT_4B}, 0, 0);
    chk(status.four_byte, 1'b0);
    send('{OP_QUAD_ENTER}, 0, 0);
    chk(status.quad, 1'b1);
    send('{OP_QUAD_EXIT}, 0, 0);
    chk(status.quad, 1'b0);
    crc = crc_of(0, 15);
    crc_run(OPT_WHOLE, ~crc, 0, 0, 0);
    apb(1'b0, REG_STATUS);
    chk(rd[FAIL_BIT], 1'b1);
    bufchk(crc);
    send('{OP_READ_BUF}, 0, 9);
    for (int i = 0; i < 9; i++) chk(h.rd_q[i], 8'(crc >> 8*i));
    send('{OP_QUAD_ENTER}, 0, 0);
    send('{OP_READ_BUF}, 0, 9);
    for (int i = 0; i < 9; i++) chk(h.rd_q[i], 8'(crc >> 8*i));
    send('{OP_QUAD_EXIT}, 0, 0);
    apb(1'b1, REG_STATUS);
    crc_run(OPT_WHOLE, crc, 0, 0, 0);
    bufchk(64'h0);
    crc_run(OPT_WHOLE, ~crc, 0, 0, 1);
    apb(1'b0, REG_STATUS);
    chk(rd[FAIL_BIT], 1'b0);
    crc_run(OPT_RANGE, 64'h0, 2, 5, 0);
    bufchk(crc_of(2, 5));
    send('{OP_CLR_FLAG}, 0, 0);
    chk(status.crc_fail, 1'b0);
    write_busy <= 1'b1;
    send('{OP_PD_ENTER}, 0, 0);
    chk(status.pending, 1'b0);
    write_busy <= 1'b0;
    send('{OP_WR_EN}, 0, 0);
    send('{OP_PD_ENTER}, 0, 0);
    chk(status.pending, 1'b1);
    repeat (DP_CYC) @(posedge clk);
    chk(status.power_down, 1'b1);
    send('{OP_ENTER_4B}, 0, 0);
    chk(status.four_byte, 1'b0);
    chk(status.wpl, 1'b1);
    send('{OP_PD_RELEASE}, 1, 0);
    chk(status.pending, 1'b0);
    send('{OP_PD_RELEASE}, 0, 0);
    chk(status.pending, 1'b1);
    repeat (RDP_CYC) @(posedge clk);
    chk(status.power_down, 1'b0);
    chk(status.pending, 1'b0);
    send('{OP_PD_ENTER}, 0, 0);
    repeat (DP_CYC) @(posedge clk);
    chk(status.power_down, 1'b1);
    hw_rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    hw_rst_n <= 1'b1;
    repeat (RST_CYC + 20) @(posedge clk);
    chk(status.power_down, 1'b0);
    chk(status.pending, 1'b0);
    bufchk(64'h0);
    send('{OP_PD_ENTER}, 0, 0);
    repeat (DP_CYC) @(posedge clk);
    chk(status.power_down, 1'b1);
    send('{OP_RST_EN}, 0, 0);
    send('{OP_RST}, 0, 0);
    chk(status.pending, 1'b1);
    repeat (RST_CYC) @(posedge clk);
    chk(status.pending, 1'b0);
    chk(status.power_down, 1'b0);
    end_of_test();
  end
endmodule // flash_mode_power_crc_commands_test
`default_nettype wire
